// file: shared/rcr_pkg.sv
// Constants, register map and carriers of the reset cause recorder
package rcr_pkg;
  // Register indices; byte address is four times the index
  localparam logic [9:0] IDX_STATUS = 10'h003;
  localparam logic [9:0] IDX_IRQCTL = 10'h00b;
  localparam logic [9:0] IDX_PERIRQ = 10'h00c;
  localparam logic [9:0] IDX_PWRCAUSE = 10'h08e;
  localparam logic [9:0] IDX_FDATH = 10'h195;
  localparam logic [9:0] IDX_OSCT = 10'h198;
  localparam logic [9:0] IDX_DOVT = 10'h199;
  localparam logic [9:0] IDX_TEMPT = 10'h19a;
  localparam logic [9:0] IDX_BGRT = 10'h19b;
  localparam logic [9:0] IDX_REFT = 10'h19c;
  localparam logic [9:0] IDX_ZROT = 10'h19d;
  localparam logic [9:0] IDX_ATST = 10'h19f;
  localparam logic [9:0] IDX_EVSTAT = 10'h1a0;
  localparam logic [9:0] IDX_EVMASK = 10'h1a1;
  localparam logic [9:0] IDX_RSTPC = 10'h1a2;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_VECTOR = 13'h0004;
  localparam int ST_WDX = 4;
  localparam int ST_SLP = 3;
  localparam int PC_OVT = 2;
  localparam int PC_POR = 1;
  localparam int IC_IRQEN = 7;
  localparam logic [7:0] RST_STATUS = 8'h18;
  localparam logic [7:0] RST_PWRCAUSE = 8'h00;
  localparam logic [7:0] RST_FDATH = 8'h00;
  localparam logic [7:0] RST_ATST = 8'h11;
  localparam logic [7:0] MSK_PWRCAUSE = 8'h06;
  localparam logic [7:0] MSK_FDATH = 8'h3f;
  localparam logic [7:0] MSK_OSCT = 8'h7f;
  localparam logic [7:0] MSK_TRIM = 8'h0f;
  localparam logic [7:0] MSK_ATST = 8'h1f;
  localparam logic [7:0] MSK_ST_SW = 8'he7;
  localparam logic [4:0] ST_UP_POR = 5'b00011;
  localparam logic [4:0] ST_UP_EXTSLP = 5'b00010;
  localparam int EVW = 5;
  typedef struct packed {
    logic por;
    logic extPin;
    logic dog;
    logic ovTemp;
    logic irqWake;
  } rcr_evt_s;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } rcr_apb_s;
  typedef enum logic [2:0] {
    CS_NONE = 3'b000,
    CS_POR = 3'b001,
    CS_EXTRUN = 3'b010,
    CS_EXTSLP = 3'b011,
    CS_DOGRUN = 3'b100,
    CS_DOGSLP = 3'b101,
    CS_OVTEMP = 3'b110,
    CS_WAKE = 3'b111
  } rcr_cause_e;
endpackage : rcr_pkg

// file: design/rcr_recorder.sv
// Reset and wake-up cause recorder with APB register file
`timescale 1ns/100ps
module rcr_recorder (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire rcr_pkg::rcr_evt_s evt,
  input wire logic asleep,
  input wire logic [12:0] pcNow,
  input wire logic [2:0] wakeIrqCtl,
  input wire logic [7:0] wakePirx,
  input wire rcr_pkg::rcr_apb_s apbReq,
  output logic pready,
  output logic pslverr,
  output logic [31:0] prdata,
  output logic restartLoad,
  output logic [12:0] restartPc,
  output logic vectorReq,
  output logic globalIrqEnable,
  output logic irqOut
);
  import rcr_pkg::*;

  logic [7:0] cpuStateFlags;
  logic [7:0] powerCauseReg;
  logic [7:0] irqControlReg;
  logic [7:0] peripheralIrqFlags;
  logic [7:0] flashDataHigh;
  logic [7:0] oscTrim;
  logic [7:0] outVoltTrim;
  logic [7:0] tempTrim;
  logic [7:0] bandgapTrim;
  logic [7:0] refOffTrim;
  logic [7:0] zeroOffTrim;
  logic [7:0] analogTestControl;
  logic [EVW-1:0] evStat;
  logic [EVW-1:0] evMask;
  logic [EVW-1:0] next_evStat;
  rcr_cause_e next_cause;
  logic [9:0] idx;
  logic wrEn;
  logic [7:0] wb;
  logic isReset;
  logic isWake;

  // ----------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------
  function automatic logic mapped(input logic [9:0] i);
    case (i)
      IDX_STATUS, IDX_IRQCTL, IDX_PERIRQ, IDX_PWRCAUSE, IDX_FDATH,
      IDX_OSCT, IDX_DOVT, IDX_TEMPT, IDX_BGRT, IDX_REFT,
      IDX_ZROT, IDX_ATST, IDX_EVSTAT, IDX_EVMASK,
      IDX_RSTPC: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction : mapped

  function automatic logic writes(input logic [9:0] i);
    writes = wrEn && (idx == i);
  endfunction : writes

  function automatic logic [7:0] upd(input logic [7:0] cur,
    input logic [9:0] i, input logic [7:0] m);
    upd = writes(i) ? (wb & m) : cur;
  endfunction : upd

  // ----------------------------------------------------------
  // Cause decode
  // ----------------------------------------------------------
  assign idx = apbReq.paddr[11:2];
  assign wb = apbReq.pwdata[7:0];
  assign wrEn = apbReq.psel && apbReq.penable && pready &&
    apbReq.pwrite && mapped(idx);

  always_comb begin
    if (evt.por) begin
      next_cause = CS_POR;
    end else if (evt.extPin) begin
      next_cause = asleep ? CS_EXTSLP : CS_EXTRUN;
    end else if (evt.dog) begin
      next_cause = asleep ? CS_DOGSLP : CS_DOGRUN;
    end else if (evt.ovTemp) begin
      next_cause = CS_OVTEMP;
    end else if (evt.irqWake && asleep) begin
      next_cause = CS_WAKE;
    end else begin
      next_cause = CS_NONE;
    end
  end

  assign isReset = (next_cause == CS_POR) ||
    (next_cause == CS_EXTRUN) || (next_cause == CS_EXTSLP) ||
    (next_cause == CS_DOGRUN) || (next_cause == CS_OVTEMP);
  assign isWake = (next_cause == CS_DOGSLP) ||
    (next_cause == CS_WAKE);

  // ----------------------------------------------------------
  // Status register
  // ----------------------------------------------------------
  // cause bits follow the event
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      cpuStateFlags <= RST_STATUS;
    end else begin
      case (next_cause)
        CS_POR: cpuStateFlags[7:3] <= ST_UP_POR;
        CS_EXTRUN: cpuStateFlags[7:5] <= 3'h0;
        CS_EXTSLP: cpuStateFlags[7:3] <= ST_UP_EXTSLP;
        CS_DOGRUN: cpuStateFlags[7:4] <= 4'h0;
        CS_DOGSLP: cpuStateFlags[ST_WDX:ST_SLP] <= 2'b00;
        CS_WAKE: cpuStateFlags[ST_WDX:ST_SLP] <= 2'b10;
        default: begin
          // Expiry and sleep bits are hardware-owned
          if (writes(IDX_STATUS)) begin
            cpuStateFlags <= (wb & MSK_ST_SW) |
              (cpuStateFlags & ~MSK_ST_SW);
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Power cause register
  // ----------------------------------------------------------
  // Hardware clears win over a software set in the same cycle
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      powerCauseReg <= RST_PWRCAUSE;
    end else begin
      // only bits 2 and 1 exist
      if (writes(IDX_PWRCAUSE)) begin
        powerCauseReg <= wb & MSK_PWRCAUSE;
      end
      if (evt.por) begin
        powerCauseReg[PC_POR] <= 1'b0;
      end
      if (evt.ovTemp) begin
        powerCauseReg[PC_OVT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Interrupt control and peripheral flags
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      irqControlReg <= 8'h00;
      peripheralIrqFlags <= 8'h00;
    end else begin
      if (writes(IDX_IRQCTL)) begin
        irqControlReg <= wb;
      end
      if (writes(IDX_PERIRQ)) begin
        peripheralIrqFlags <= wb;
      end
      // wake source flags win over a clear
      if (next_cause == CS_WAKE) begin
        irqControlReg[2:0] <= wakeIrqCtl |
          (writes(IDX_IRQCTL) ? wb[2:0] : irqControlReg[2:0]);
        peripheralIrqFlags <= wakePirx |
          (writes(IDX_PERIRQ) ? wb : peripheralIrqFlags);
      end
      if (isReset) begin
        irqControlReg[IC_IRQEN] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Calibration and flash data registers
  // ----------------------------------------------------------
  // Trims have no defined reset value; zero is only a start value
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      flashDataHigh <= RST_FDATH;
      analogTestControl <= RST_ATST;
      oscTrim <= 8'h00;
      outVoltTrim <= 8'h00;
      tempTrim <= 8'h00;
      bandgapTrim <= 8'h00;
      refOffTrim <= 8'h00;
      zeroOffTrim <= 8'h00;
    end else begin
      flashDataHigh <= upd(flashDataHigh, IDX_FDATH, MSK_FDATH);
      analogTestControl <= upd(analogTestControl, IDX_ATST, MSK_ATST);
      oscTrim <= upd(oscTrim, IDX_OSCT, MSK_OSCT);
      outVoltTrim <= upd(outVoltTrim, IDX_DOVT, MSK_TRIM);
      tempTrim <= upd(tempTrim, IDX_TEMPT, MSK_TRIM);
      bandgapTrim <= upd(bandgapTrim, IDX_BGRT, MSK_TRIM);
      refOffTrim <= upd(refOffTrim, IDX_REFT, MSK_TRIM);
      zeroOffTrim <= upd(zeroOffTrim, IDX_ZROT, MSK_TRIM);
      // defined resets reload, wakes keep contents
      if (next_cause == CS_POR || next_cause == CS_EXTRUN ||
          next_cause == CS_EXTSLP || next_cause == CS_DOGRUN) begin
        flashDataHigh <= RST_FDATH;
        analogTestControl <= RST_ATST;
      end
    end
  end

  // ----------------------------------------------------------
  // Restart point to the core
  // ----------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      restartLoad <= 1'b0;
      restartPc <= PC_RESET;
      vectorReq <= 1'b0;
    end else begin
      restartLoad <= isReset || isWake;
      vectorReq <= 1'b0;
      if (isReset) begin
        restartPc <= PC_RESET;
      end else if (isWake) begin
        restartPc <= pcNow + 13'h0001;
      end
      if (next_cause == CS_WAKE && irqControlReg[IC_IRQEN]) begin
        vectorReq <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      globalIrqEnable <= 1'b0;
    end else begin
      globalIrqEnable <= irqControlReg[IC_IRQEN];
    end
  end

  // ----------------------------------------------------------
  // Cause events and interrupt output
  // ----------------------------------------------------------
  // New events win over a write-one clear
  always_comb begin
    next_evStat = evStat;
    if (writes(IDX_EVSTAT)) begin
      next_evStat = evStat & ~wb[EVW-1:0];
    end
    next_evStat = next_evStat | {evt.irqWake && asleep, evt.ovTemp,
      evt.dog, evt.extPin, evt.por};
  end

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      evStat <= '0;
      evMask <= '0;
      irqOut <= 1'b0;
    end else begin
      evStat <= next_evStat;
      if (writes(IDX_EVMASK)) begin
        evMask <= wb[EVW-1:0];
        irqOut <= |(next_evStat & wb[EVW-1:0]);
      end else begin
        irqOut <= |(next_evStat & evMask);
      end
    end
  end

  // ----------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------
  // Read data is sampled in setup, so one access cycle and no waits
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apbReq.psel && !apbReq.penable;
      pslverr <= apbReq.psel && !apbReq.penable && !mapped(idx);
      prdata <= 32'h0000_0000;
      if (apbReq.psel && !apbReq.penable && !apbReq.pwrite) begin
        case (idx)
          IDX_STATUS: prdata[7:0] <= cpuStateFlags;
          IDX_IRQCTL: prdata[7:0] <= irqControlReg;
          IDX_PERIRQ: prdata[7:0] <= peripheralIrqFlags;
          IDX_PWRCAUSE: prdata[7:0] <= powerCauseReg & MSK_PWRCAUSE;
          IDX_FDATH: prdata[7:0] <= flashDataHigh;
          IDX_OSCT: prdata[7:0] <= oscTrim;
          IDX_DOVT: prdata[7:0] <= outVoltTrim;
          IDX_TEMPT: prdata[7:0] <= tempTrim;
          IDX_BGRT: prdata[7:0] <= bandgapTrim;
          IDX_REFT: prdata[7:0] <= refOffTrim;
          IDX_ZROT: prdata[7:0] <= zeroOffTrim;
          IDX_ATST: prdata[7:0] <= analogTestControl;
          IDX_EVSTAT: prdata[EVW-1:0] <= evStat;
          IDX_EVMASK: prdata[EVW-1:0] <= evMask;
          IDX_RSTPC: prdata[12:0] <= restartPc;
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  chk_por_status: assert property (@(posedge clk_sys)
    disable iff (!nrst) evt.por |=> cpuStateFlags[7:3] == 5'b00011
      && !powerCauseReg[PC_POR] && restartLoad && restartPc == 13'h0)
    else $error("power-on cause not recorded");
  chk_overtemp_flag: assert property (@(posedge clk_sys)
    disable iff (!nrst) evt.ovTemp |=> !powerCauseReg[PC_OVT])
    else $error("overtemperature flag not cleared");
  chk_ext_run: assert property (@(posedge clk_sys)
    disable iff (!nrst) (evt.extPin && !evt.por && !asleep) |=>
      cpuStateFlags[7:5] == 3'h0 &&
      cpuStateFlags[4:3] == $past(cpuStateFlags[4:3]) &&
      powerCauseReg == $past(powerCauseReg))
    else $error("pin reset altered kept bits");
  chk_ext_sleep: assert property (@(posedge clk_sys)
    disable iff (!nrst) (evt.extPin && !evt.por && asleep) |=>
      cpuStateFlags[ST_WDX] && !cpuStateFlags[ST_SLP] &&
      restartPc == 13'h0)
    else $error("pin reset in sleep wrong");
  chk_watchdog_run: assert property (@(posedge clk_sys)
    disable iff (!nrst) (evt.dog && !evt.por && !evt.extPin &&
      !asleep) |=> !cpuStateFlags[ST_WDX] &&
      cpuStateFlags[ST_SLP] == $past(cpuStateFlags[ST_SLP]))
    else $error("watchdog reset wrong");
  chk_watchdog_wake: assert property (@(posedge clk_sys)
    disable iff (!nrst) (next_cause == CS_DOGSLP) |=>
      cpuStateFlags[4:3] == 2'b00 &&
      restartPc == $past(pcNow) + 13'h0001)
    else $error("watchdog wake wrong");
  chk_irq_wake: assert property (@(posedge clk_sys)
    disable iff (!nrst) (next_cause == CS_WAKE) |=>
      cpuStateFlags[4:3] == 2'b10 &&
      (peripheralIrqFlags & $past(wakePirx)) == $past(wakePirx))
    else $error("interrupt wake wrong");
  chk_vector_req: assert property (@(posedge clk_sys)
    disable iff (!nrst) (next_cause == CS_WAKE &&
      irqControlReg[IC_IRQEN]) |=> vectorReq ##1 !vectorReq)
    else $error("vector request missing");
  chk_cal_keep: assert property (@(posedge clk_sys)
    disable iff (!nrst) isWake |=> $stable(flashDataHigh) &&
      $stable(analogTestControl))
    else $error("wake altered calibration");
  chk_unimpl_zero: assert property (@(posedge clk_sys)
    disable iff (!nrst) (powerCauseReg & ~MSK_PWRCAUSE) == 8'h00)
    else $error("unimplemented bit set");
  chk_irqen_clear: assert property (@(posedge clk_sys)
    disable iff (!nrst) isReset |=> !irqControlReg[IC_IRQEN]
      ##1 !globalIrqEnable)
    else $error("reset left interrupt enable set");

endmodule : rcr_recorder

// file: dv/tb_top.sv
// Self-checking bench of the reset cause recorder over APB and event ports
`timescale 1ns/100ps
module tb_top;
  import rcr_pkg::*;
  logic clk_sys;
  logic nrst;
  rcr_evt_s evt;
  logic asleep;
  logic [12:0] pcNow;
  logic [2:0] wakeIrqCtl;
  logic [7:0] wakePirx;
  rcr_apb_s apbReq;
  logic pready;
  logic pslverr;
  logic [31:0] prdata;
  logic restartLoad;
  logic [12:0] restartPc;
  logic vectorReq;
  logic globalIrqEnable;
  logic irqOut;
  int n_errors = 0;
  int num_checks = 0;

  rcr_recorder rcr_recorder_inst (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .evt(evt),
    .asleep(asleep),
    .pcNow(pcNow),
    .wakeIrqCtl(wakeIrqCtl),
    .wakePirx(wakePirx),
    .apbReq(apbReq),
    .pready(pready),
    .pslverr(pslverr),
    .prdata(prdata),
    .restartLoad(restartLoad),
    .restartPc(restartPc),
    .vectorReq(vectorReq),
    .globalIrqEnable(globalIrqEnable),
    .irqOut(irqOut)
  );

  always #2.5 clk_sys = ~clk_sys;

  // ----------------------------------------
  // Checking and closing
  // ----------------------------------------
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // ----------------------------------------
  // APB master
  // ----------------------------------------
  // Waits are bounded so a dead slave ends the run instead of hanging
  task automatic xfer(input logic w, input logic [9:0] idx,
                      input logic [31:0] wd, output logic [31:0] rdat,
                      output logic err);
    int n;
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= w;
    apbReq.paddr <= {idx, 2'b00};
    apbReq.pwdata <= wd;
    @(posedge clk_sys);
    apbReq.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("Error pready expected 1 seen timeout");
      wrap_up();
    end
    rdat = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge clk_sys);
  endtask : xfer

  task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
    logic [31:0] d;
    logic e;
    xfer(1'b1, idx, wd, d, e);
  endtask : wr

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp,
                    input logic expErr = 1'b0,
                    input logic [31:0] m = 32'hffffffff);
    logic [31:0] d;
    logic e;
    xfer(1'b0, idx, 32'h0, d, e);
    chk($sformatf("reg %h", idx), d & m, exp);
    chk($sformatf("pslverr %h", idx), 32'(e), 32'(expErr));
  endtask : rd

  // ----------------------------------------
  // Event driver: one-cycle pulse, answer one edge later
  // ----------------------------------------
  task automatic ev(input logic [4:0] e, input logic slp,
                    input logic [12:0] pc, input logic ld,
                    input logic [12:0] expPc, input logic vec);
    evt <= e;
    asleep <= slp;
    pcNow <= pc;
    @(posedge clk_sys);
    evt <= '0;
    @(negedge clk_sys);
    chk("restartLoad", 32'(restartLoad), 32'(ld));
    chk("restartPc", 32'(restartPc), 32'(expPc));
    chk("vectorReq", 32'(vectorReq), 32'(vec));
    @(posedge clk_sys);
  endtask : ev

  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    nrst = 1'b0;
    evt = '0;
    asleep = 1'b0;
    pcNow = 13'h0000;
    wakeIrqCtl = 3'b101;
    wakePirx = 8'h81;
    apbReq = '0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);

    rd(IDX_STATUS, 32'h18);
    rd(IDX_PWRCAUSE, 32'h00);
    rd(IDX_IRQCTL, 32'h00);
    rd(IDX_FDATH, 32'h00);
    rd(IDX_ATST, 32'h11);
    rd(10'h1ff, 32'h0, 1'b1);
    wr(IDX_PWRCAUSE, 32'hff);
    rd(IDX_PWRCAUSE, 32'h06);
    wr(IDX_STATUS, 32'h00);
    rd(IDX_STATUS, 32'h18);
    for (int i = 'h198; i <= 'h19d; i++) begin
      rd(10'(i), 32'h0);
      wr(10'(i), 32'hff);
      rd(10'(i), (i == 'h198) ? 32'h7f : 32'h0f);
    end
    wr(IDX_FDATH, 32'hff);
    rd(IDX_FDATH, 32'h3f);
    wr(IDX_ATST, 32'hff);
    rd(IDX_ATST, 32'h1f);
    $display("test registers done");

    // Power-on coinciding with pin and watchdog resets
    wr(IDX_IRQCTL, 32'h80);
    rd(IDX_IRQCTL, 32'h80);
    ev(5'b11100, 1'b0, 13'h0100, 1'b1, PC_RESET, 1'b0);
    rd(IDX_STATUS, 32'h18, 1'b0, 32'hf8);
    rd(IDX_PWRCAUSE, 32'h04);
    rd(IDX_IRQCTL, 32'h00);
    chk("globalIrqEnable", 32'(globalIrqEnable), 32'h0);
    rd(IDX_FDATH, 32'h00);
    rd(IDX_ATST, 32'h11);
    $display("test power-on done");

    // Watchdog wake keeps calibration and interrupt enable
    wr(IDX_STATUS, 32'he5);
    wr(IDX_FDATH, 32'h2a);
    wr(IDX_ATST, 32'h05);
    wr(IDX_BGRT, 32'h03);
    wr(IDX_IRQCTL, 32'h80);
    ev(5'b00100, 1'b1, 13'h0123, 1'b1, 13'h0124, 1'b0);
    rd(IDX_STATUS, 32'he5);
    rd(IDX_FDATH, 32'h2a);
    rd(IDX_ATST, 32'h05);
    rd(IDX_BGRT, 32'h03);
    rd(IDX_IRQCTL, 32'h80);
    $display("test watchdog wake done");

    wr(IDX_PWRCAUSE, 32'h06);
    wr(IDX_STATUS, 32'he7);
    ev(5'b01000, 1'b0, 13'h0200, 1'b1, PC_RESET, 1'b0);
    rd(IDX_STATUS, 32'h07);
    rd(IDX_PWRCAUSE, 32'h06);
    rd(IDX_IRQCTL, 32'h00);
    ev(5'b01000, 1'b1, 13'h0200, 1'b1, PC_RESET, 1'b0);
    rd(IDX_STATUS, 32'h17);
    rd(IDX_PWRCAUSE, 32'h06);
    wr(IDX_STATUS, 32'he0);
    ev(5'b00100, 1'b0, 13'h0300, 1'b1, PC_RESET, 1'b0);
    rd(IDX_STATUS, 32'h00);
    rd(IDX_PWRCAUSE, 32'h06);
    rd(IDX_FDATH, 32'h00);
    rd(IDX_ATST, 32'h11);
    rd(IDX_BGRT, 32'h03);
    $display("test pin and watchdog resets done");

    // Interrupt wake, with and without the global enable
    wr(IDX_IRQCTL, 32'h80);
    ev(5'b00001, 1'b1, 13'h0ffe, 1'b1, 13'h0fff, 1'b1);
    rd(IDX_STATUS, 32'h10);
    rd(IDX_IRQCTL, 32'h85);
    rd(IDX_PERIRQ, 32'h81);
    chk("globalIrqEnable", 32'(globalIrqEnable), 32'h1);
    ev(5'b00001, 1'b0, 13'h0050, 1'b0, 13'h0fff, 1'b0);
    wr(IDX_IRQCTL, 32'h00);
    ev(5'b00001, 1'b1, 13'h0010, 1'b1, 13'h0011, 1'b0);
    $display("test interrupt wake done");

    ev(5'b00010, 1'b0, 13'h0400, 1'b1, PC_RESET, 1'b0);
    rd(IDX_PWRCAUSE, 32'h02);
    rd(IDX_RSTPC, 32'h0000);
    wr(IDX_RSTPC, 32'h1234);
    rd(IDX_RSTPC, 32'h0000);
    $display("test overtemperature done");

    // Sticky event status, mask and interrupt line
    rd(IDX_EVSTAT, 32'h1f);
    chk("irqOut", 32'(irqOut), 32'h0);
    wr(IDX_EVMASK, 32'h08);
    chk("irqOut", 32'(irqOut), 32'h1);
    wr(IDX_EVSTAT, 32'h08);
    chk("irqOut", 32'(irqOut), 32'h0);
    rd(IDX_EVSTAT, 32'h17);
    wr(IDX_EVSTAT, 32'h1f);
    rd(IDX_EVSTAT, 32'h00);
    $display("test interrupt line done");
    wrap_up();
  end
endmodule : tb_top
